// *** logic/boot_loader_defs.svh ***
`ifndef BOOT_LOADER_DEFS_SVH
`define BOOT_LOADER_DEFS_SVH

// One serial clock period in core clock cycles and the points inside it.
`define BOOT_SCL_DIV       9'd293
`define BOOT_PH_DATA       9'd73
`define BOOT_PH_RISE       9'd146
`define BOOT_PH_SAMPLE     9'd219

// Serial memory control bytes: device code, chip pins 000, direction bit.
`define BOOT_CTRL_WR       8'ha0
`define BOOT_CTRL_RD       8'ha1

// Image locations.
`define BOOT_VID_LO        8'h40
`define BOOT_VID_HI        8'h41
`define BOOT_SIG0_ADDR     8'h50
`define BOOT_SIG1_ADDR     8'h51
`define BOOT_SIG2_ADDR     8'h52
`define BOOT_SIG3_ADDR     8'h53
`define BOOT_IMG_FIRST     8'h40
`define BOOT_IMG_LAST_CNT  6'd63
`define BOOT_MODE_OFFSET   6'd5
`define BOOT_CHECK_LAST    3'd5

// Expected signature and blank values.
`define BOOT_BLANK         8'hff
`define BOOT_SIG0_MEM      8'h80
`define BOOT_SIG0_IO       8'h81
`define BOOT_SIG0_LOW      8'h82
`define BOOT_SIG1          8'hff
`define BOOT_SIG2          8'he8
`define BOOT_SIG3          8'h10

// Serial clock slots of a random one-byte write transaction.
`define BOOT_WR_SLOTS      5'd29

// Operation steps of one serial transaction.
`define BOOT_OP_START      3'd0
`define BOOT_OP_CTRL_WR    3'd1
`define BOOT_OP_ADDR       3'd2
`define BOOT_OP_RESTART    3'd3
`define BOOT_OP_CTRL_RD    3'd4
`define BOOT_OP_READ       3'd5
`define BOOT_OP_STOP       3'd6

// Data buffer depth.
`define BOOT_FIFO_DEPTH    16

`endif

// *** logic/boot_pkg.sv ***
`default_nettype none

package boot_pkg;

  typedef struct packed {
    logic [5:0] offset;
    logic [7:0] data;
  } cfg_write_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SLOT = 3'b010,
    ST_DONE = 3'b100
  } boot_state_t;

endpackage : boot_pkg

`default_nettype wire

// *** logic/serial_eeprom_boot_loader.sv ***
`include "boot_loader_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module cfg_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;

  // The extra pointer bit tells a full buffer from an empty one.
  assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
    end else if (in_valid && in_ready) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= '0;
    end else if (out_valid && out_ready) begin
      rd_q <= rd_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule : cfg_fifo

module serial_eeprom_boot_loader (
  // Clock and reset
  input  wire logic           core_clk,
  input  wire logic           reset_n,
  // Serial memory pins
  output logic                scl_o,
  output logic                scl_oe,
  input  wire logic           sda_i,
  output logic                sda_o,
  output logic                sda_oe,
  // Configuration write stream
  output logic                cfg_wr_valid,
  output boot_pkg::cfg_write_t cfg_wr,
  input  wire logic           cfg_wr_ready,
  // Boot status
  output logic                cfg_retry,
  output logic                cfg_ready,
  output logic                addon_enable,
  output logic                image_absent,
  output logic [7:0]          mode_byte
);
  import boot_pkg::*;

  logic        rst_s1_q;
  logic        rst_s2_q;
  logic        sda_s1_q;
  logic        sda_s2_q;
  boot_state_t state_q;
  logic [8:0]  div_q;
  logic [2:0]  op_q;
  logic [3:0]  bit_q;
  logic [2:0]  idx_q;
  logic [5:0]  cnt_q;
  logic        seq_q;
  logic        fail_q;
  logic        absent_q;
  logic        addon_q;
  logic        retry_q;
  logic        ready_q;
  logic        pin_low_q;
  logic        scl_oe_q;
  logic        sda_oe_q;
  logic [7:0]  rx_q;
  logic [7:0]  first_q;
  logic [7:0]  mode_q;
  logic        out_valid_q;
  cfg_write_t  out_data_q;

  logic        slot_end;
  logic        is_byte;
  logic        last_bit;
  logic        more_seq;
  logic        capture;
  logic        sample;
  logic        to_fifo;
  logic        stall;
  logic        byte_ok;
  logic        drive_low;
  logic [7:0]  mem_addr;
  logic [7:0]  tx_byte;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  cfg_write_t  fifo_in_data;
  cfg_write_t  fifo_out_data;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
    end
  end

  // Memory address of each check read, then the image start for the burst.
  always_comb begin
    mem_addr = `BOOT_IMG_FIRST;
    if (!seq_q) begin
      unique case (idx_q)
        3'd0:    mem_addr = `BOOT_VID_LO;
        3'd1:    mem_addr = `BOOT_VID_HI;
        3'd2:    mem_addr = `BOOT_SIG0_ADDR;
        3'd3:    mem_addr = `BOOT_SIG1_ADDR;
        3'd4:    mem_addr = `BOOT_SIG2_ADDR;
        default: mem_addr = `BOOT_SIG3_ADDR;
      endcase
    end
  end

  // Addresses stay below 100h, so the block bits of the control byte are zero.
  always_comb begin
    unique case (op_q)
      `BOOT_OP_CTRL_WR: tx_byte = `BOOT_CTRL_WR;
      `BOOT_OP_ADDR:    tx_byte = mem_addr;
      `BOOT_OP_CTRL_RD: tx_byte = `BOOT_CTRL_RD;
      default:          tx_byte = 8'h00;
    endcase
  end

  // Signature and blank checks on the byte just received.
  always_comb begin
    unique case (idx_q)
      3'd1:    byte_ok = (first_q != `BOOT_BLANK) || (rx_q != `BOOT_BLANK);
      3'd2:    byte_ok = (rx_q == `BOOT_SIG0_MEM) || (rx_q == `BOOT_SIG0_IO)
                         || (rx_q == `BOOT_SIG0_LOW);
      3'd3:    byte_ok = rx_q == `BOOT_SIG1;
      3'd4:    byte_ok = rx_q == `BOOT_SIG2;
      3'd5:    byte_ok = rx_q == `BOOT_SIG3;
      default: byte_ok = 1'b1;
    endcase
  end

  assign is_byte  = (op_q == `BOOT_OP_CTRL_WR) || (op_q == `BOOT_OP_ADDR)
                    || (op_q == `BOOT_OP_CTRL_RD) || (op_q == `BOOT_OP_READ);
  assign last_bit = !is_byte || (bit_q == 4'd8);
  assign slot_end = (state_q == ST_SLOT) && (div_q == `BOOT_SCL_DIV - 9'd1);
  assign more_seq = seq_q && (cnt_q != `BOOT_IMG_LAST_CNT);
  assign sample   = (state_q == ST_SLOT) && (div_q == `BOOT_PH_SAMPLE);
  assign capture  = (state_q == ST_SLOT) && (op_q == `BOOT_OP_READ) && (bit_q == 4'd8)
                    && (div_q == `BOOT_PH_DATA);
  assign to_fifo  = capture && seq_q && (cnt_q != `BOOT_MODE_OFFSET);
  // A full buffer holds the serial clock low in the acknowledge slot.
  assign stall    = to_fifo && !fifo_in_ready;

  // Level that the data line takes at the data phase of the current slot.
  always_comb begin
    unique case (op_q)
      `BOOT_OP_START, `BOOT_OP_RESTART: drive_low = 1'b0;
      `BOOT_OP_STOP:                    drive_low = 1'b1;
      `BOOT_OP_READ:                    drive_low = (bit_q == 4'd8) && more_seq;
      default:                          drive_low = (bit_q != 4'd8) && !tx_byte[3'd7 - bit_q[2:0]];
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      div_q <= 9'd0;
    end else if ((state_q != ST_SLOT) || slot_end) begin
      div_q <= 9'd0;
    end else if (!stall) begin
      div_q <= div_q + 9'd1;
    end
  end

  // Transactions: start, control, address, restart, control, read, stop.
  // A write would add a data byte after the address; 29 slots in all.
  always_ff @(posedge core_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      state_q <= ST_IDLE;
      op_q    <= `BOOT_OP_START;
      bit_q   <= 4'd0;
      idx_q   <= 3'd0;
      cnt_q   <= 6'd0;
      seq_q   <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // The bus is taken as idle and ours alone; no arbitration.
          state_q <= ST_SLOT;
        end
        ST_SLOT: begin
          if (slot_end && !last_bit) begin
            bit_q <= bit_q + 4'd1;
          end else if (slot_end) begin
            bit_q <= 4'd0;
            unique case (op_q)
              `BOOT_OP_STOP: begin
                if (fail_q || seq_q) begin
                  state_q <= ST_DONE;
                end else begin
                  op_q <= `BOOT_OP_START;
                  if (idx_q == `BOOT_CHECK_LAST) begin
                    seq_q <= 1'b1;
                  end else begin
                    idx_q <= idx_q + 3'd1;
                  end
                end
              end
              `BOOT_OP_READ: begin
                if (more_seq) begin
                  cnt_q <= cnt_q + 6'd1;
                end else begin
                  op_q <= `BOOT_OP_STOP;
                end
              end
              `BOOT_OP_CTRL_WR, `BOOT_OP_ADDR, `BOOT_OP_CTRL_RD: begin
                op_q <= fail_q ? `BOOT_OP_STOP : op_q + 3'd1;
              end
              default: op_q <= op_q + 3'd1;
            endcase
          end
        end
        ST_DONE: state_q <= ST_DONE;
      endcase
    end
  end

  // Clock falls at the slot start and rises at mid slot, so data moves
  // only while the clock is low; start and stop move it while high.
  always_ff @(posedge core_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (state_q != ST_SLOT) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      if (div_q == 9'd0) begin
        scl_oe_q <= 1'b1;
      end else if (div_q == `BOOT_PH_RISE) begin
        scl_oe_q <= 1'b0;
      end
      if (div_q == `BOOT_PH_DATA) begin
        sda_oe_q <= drive_low;
      end else if (sample && ((op_q == `BOOT_OP_START) || (op_q == `BOOT_OP_RESTART))) begin
        sda_oe_q <= 1'b1;
      end else if (sample && (op_q == `BOOT_OP_STOP)) begin
        sda_oe_q <= 1'b0;
      end
    end
  end

  // The lines are only ever pulled low.
  always_ff @(posedge core_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      pin_low_q <= 1'b0;
    end else begin
      pin_low_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      rx_q <= 8'h00;
    end else if (sample && (op_q == `BOOT_OP_READ) && (bit_q != 4'd8)) begin
      rx_q <= {rx_q[6:0], sda_s2_q};
    end
  end

  always_ff @(posedge core_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      fail_q   <= 1'b0;
      absent_q <= 1'b0;
    end else if (sample && is_byte && (op_q != `BOOT_OP_READ) && (bit_q == 4'd8)
                 && sda_s2_q) begin
      fail_q   <= 1'b1;
      absent_q <= 1'b1;
    end else if (capture && !seq_q && !byte_ok) begin
      fail_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      first_q <= 8'h00;
    end else if (capture && !seq_q && (idx_q == 3'd0)) begin
      first_q <= rx_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      mode_q <= 8'h00;
    end else if (capture && seq_q && (cnt_q == `BOOT_MODE_OFFSET)) begin
      mode_q <= rx_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      addon_q <= 1'b0;
    end else if (slot_end && (op_q == `BOOT_OP_STOP) && seq_q && !fail_q) begin
      addon_q <= 1'b1;
    end
  end

  // Configuration stays in retry until the last image byte has left.
  always_ff @(posedge core_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      retry_q <= 1'b1;
      ready_q <= 1'b0;
    end else begin
      retry_q <= !((state_q == ST_DONE) && !fifo_out_valid && !out_valid_q);
      ready_q <= (state_q == ST_DONE) && !fifo_out_valid && !out_valid_q;
    end
  end

  assign fifo_in_data.offset = cnt_q;
  assign fifo_in_data.data   = rx_q;
  assign fifo_out_ready      = !out_valid_q || cfg_wr_ready;

  cfg_fifo #(
    .WIDTH ($bits(cfg_write_t)),
    .DEPTH (`BOOT_FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst_n     (rst_s2_q),
    .in_valid  (to_fifo),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge core_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else if (fifo_out_ready) begin
      out_valid_q <= fifo_out_valid;
      if (fifo_out_valid) begin
        out_data_q <= fifo_out_data;
      end
    end
  end

  assign scl_o        = pin_low_q;
  assign sda_o        = pin_low_q;
  assign scl_oe       = scl_oe_q;
  assign sda_oe       = sda_oe_q;
  assign cfg_wr_valid = out_valid_q;
  assign cfg_wr       = out_data_q;
  assign cfg_retry    = retry_q;
  assign cfg_ready    = ready_q;
  assign addon_enable = addon_q;
  assign image_absent = absent_q;
  assign mode_byte    = mode_q;
endmodule : serial_eeprom_boot_loader

`default_nettype wire

// *** tb/boot_chk.sv ***
`timescale 1ns/1ns
`default_nettype none

module boot_chk (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 reset_n,
  // Serial pins
  input wire logic                 scl_o,
  input wire logic                 scl_oe,
  input wire logic                 sda_i,
  input wire logic                 sda_o,
  input wire logic                 sda_oe,
  // Stream and status
  input wire logic                 cfg_wr_valid,
  input wire boot_pkg::cfg_write_t cfg_wr,
  input wire logic                 cfg_wr_ready,
  input wire logic                 cfg_retry,
  input wire logic                 cfg_ready,
  input wire logic                 addon_enable,
  input wire logic                 image_absent,
  input wire logic [7:0]           mode_byte
);
  import boot_pkg::*;

  // The released half of a slot is never stretched by a stall, so its length is exact.
  logic [8:0] low_q;
  logic       seen_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_q  <= 9'h000;
      seen_q <= 1'b0;
    end else begin
      low_q  <= scl_oe ? 9'h000 : low_q + 9'h001;
      seen_q <= seen_q | scl_oe;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_open_drain; scl_o == 1'b0 && sda_o == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  property p_scl_div; $rose(scl_oe) && seen_q |-> low_q == 9'h093; endproperty
  a_scl_div: assert property (p_scl_div) else $error("serial clock period wrong");
  property p_boot_start; $rose(reset_n) |-> ##[1:10] scl_oe; endproperty
  a_boot_start: assert property (p_boot_start) else $error("boot did not start");
  property p_release; cfg_ready |-> !scl_oe && !sda_oe; endproperty
  a_release: assert property (p_release) else $error("lines held when idle");
  property p_retry; cfg_ready == !cfg_retry; endproperty
  a_retry: assert property (p_retry) else $error("retry and ready disagree");
  property p_absent_done; $rose(image_absent) |-> ##[1:700] cfg_ready; endproperty
  a_absent_done: assert property (p_absent_done) else $error("no finish after absent");
  property p_absent_nowr; image_absent |-> !cfg_wr_valid && !addon_enable; endproperty
  a_absent_nowr: assert property (p_absent_nowr) else $error("writes without memory");
  property p_hold; cfg_wr_valid && !cfg_wr_ready |=> cfg_wr_valid && $stable(cfg_wr); endproperty
  a_hold: assert property (p_hold) else $error("stream item dropped");
  property p_mode; cfg_wr_valid |-> cfg_wr.offset != 6'h05; endproperty
  a_mode: assert property (p_mode) else $error("mode byte sent as register");
  property p_done_empty; cfg_ready |-> !cfg_wr_valid; endproperty
  a_done_empty: assert property (p_done_empty) else $error("ready before drained");
endmodule : boot_chk

bind serial_eeprom_boot_loader boot_chk chk (.core_clk(core_clk), .reset_n(reset_n),
  .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .cfg_wr_valid(cfg_wr_valid), .cfg_wr(cfg_wr), .cfg_wr_ready(cfg_wr_ready),
  .cfg_retry(cfg_retry), .cfg_ready(cfg_ready), .addon_enable(addon_enable),
  .image_absent(image_absent), .mode_byte(mode_byte));

`default_nettype wire

// *** tb/eeprom_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module eeprom_model (
  // Two-wire bus, both lines pulled up outside
  input  wire logic scl,
  input  wire logic sda,
  output var logic  pull
);
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic [7:0] addr = 8'h00;
  logic       present = 1'b1;
  logic       rd = 1'b0;
  logic       ctrl = 1'b0;
  logic       mack = 1'b0;
  int         bitn = 0;
  int         starts = 0;
  int         sent = 0;

  initial pull = 1'b0;

  // A start or repeated start restarts byte framing.
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      starts++;
      bitn = 0;
      rd   = 1'b0;
      ctrl = 1'b1;
    end
  end

  always @(posedge sda) begin
    if (scl === 1'b1) begin
      bitn = 0;
      rd   = 1'b0;
    end
  end

  always @(posedge scl) begin
    bitn++;
    if (bitn == 9) mack = !sda;
    else if (!rd) sh = {sh[6:0], sda};
  end

  // Data moves only after SCL falls, as a real memory does.
  always @(negedge scl) begin
    if (bitn == 9) begin
      bitn = 0;
      pull = 1'b0;
      if (rd && mack) begin
        sh   = mem[addr];
        addr = addr + 8'h01;
        sent++;
        pull = !sh[7];
      end
    end else if (rd) begin
      pull = (bitn < 8) ? !sh[7 - bitn] : 1'b0;
    end else if (bitn == 8) begin
      pull = present;
      if (ctrl) begin
        pull = present && sh[7:1] == 7'h50;
        rd   = pull && sh[0];
      end else begin
        addr = sh;
      end
      ctrl = 1'b0;
    end
  end
endmodule : eeprom_model

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import boot_pkg::*;

  logic       core_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       rdy = 1'b1;
  logic       scl_o, scl_oe, sda_o, sda_oe, pull;
  logic       cfg_wr_valid, cfg_retry, cfg_ready, addon_enable, image_absent;
  cfg_write_t cfg_wr;
  logic [7:0] mode_byte;
  logic [7:0] got [0:63];
  logic [5:0] last_off;
  int         bad_count = 0;
  int         checked = 0;
  int         cyc = 0;
  int         nwr = 0;
  int         ord_bad = 0;
  wire        scl_w;
  wire        sda_w;

  assign scl_w = scl_oe ? scl_o : 1'b1;
  assign sda_w = !((sda_oe && !sda_o) || pull);

  serial_eeprom_boot_loader dut (.core_clk(core_clk), .reset_n(reset_n), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .cfg_wr_valid(cfg_wr_valid), .cfg_wr(cfg_wr), .cfg_wr_ready(rdy),
    .cfg_retry(cfg_retry), .cfg_ready(cfg_ready), .addon_enable(addon_enable),
    .image_absent(image_absent), .mode_byte(mode_byte));
  eeprom_model mem_m (.scl(scl_w), .sda(sda_w), .pull(pull));

  always #4 core_clk = ~core_clk;

  // A full valid boot needs about 246k cycles at the fixed divider.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 400000) begin
      bad_count++;
      print_verdict();
    end
  end

  always @(posedge core_clk) begin
    if (reset_n && cfg_wr_valid === 1'b1 && rdy) begin
      if (nwr > 0 && cfg_wr.offset <= last_off) ord_bad++;
      got[cfg_wr.offset] = cfg_wr.data;
      last_off = cfg_wr.offset;
      nwr++;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic fill(input logic [7:0] id, input logic [7:0] sig0);
    for (int i = 64; i < 128; i++) mem_m.mem[i] = 8'(i * 3 + 17);
    mem_m.mem[64] = id;
    mem_m.mem[80] = sig0;
    mem_m.mem[81] = 8'hff;
    mem_m.mem[82] = 8'he8;
    mem_m.mem[83] = 8'h10;
  endtask : fill

  task automatic boot(input logic here, input logic take);
    mem_m.present = here;
    mem_m.starts = 0;
    mem_m.sent = 0;
    nwr = 0;
    ord_bad = 0;
    @(posedge core_clk);
    #1 reset_n = 1'b0;
    rdy = take;
    repeat (3) @(posedge core_clk);
    #1 reset_n = 1'b1;
  endtask : boot

  task automatic wait_done();
    int n = 0;
    while (cfg_ready !== 1'b1 && n < 300000) begin
      @(posedge core_clk);
      n++;
    end
    #1;
  endtask : wait_done

  task automatic test_absent();
    boot(1'b0, 1'b1);
    repeat (20) @(posedge core_clk);
    check(cfg_retry, 16'h0001);
    wait_done();
    check(image_absent, 16'h0001);
    check(addon_enable, 16'h0000);
    check(nwr, 16'h0000);
    check(mode_byte, 16'h0000);
    check(mem_m.starts, 16'h0001);
  endtask : test_absent

  task automatic test_reject(input logic [7:0] id, input logic [7:0] id_hi, input logic [7:0] sig0,
                             input int nst);
    fill(id, sig0);
    mem_m.mem[65] = id_hi;
    boot(1'b1, 1'b1);
    wait_done();
    check(mem_m.starts, 16'(nst));
    check(image_absent, 16'h0000);
    check(addon_enable, 16'h0000);
    check(nwr, 16'h0000);
  endtask : test_reject

  task automatic test_valid();
    int n = 0;
    int s;
    fill(8'hd1, 8'h81);
    boot(1'b1, 1'b0);
    while (mem_m.sent < 22 && n < 250000) begin
      @(posedge core_clk);
      n++;
    end
    // The buffer, its output stage and the mode byte absorb the image up to offset 17.
    repeat (12000) @(posedge core_clk);
    s = mem_m.sent;
    repeat (3000) @(posedge core_clk);
    #1;
    check(mem_m.sent, 16'(s));
    check(16'(s), 16'h0019);
    check(scl_oe, 16'h0001);
    check(cfg_retry, 16'h0001);
    check(addon_enable, 16'h0000);
    rdy = 1'b1;
    wait_done();
    check(nwr, 16'h003f);
    check(ord_bad, 16'h0000);
    for (int i = 0; i < 64; i++) if (i != 5) check(got[i], mem_m.mem[64 + i]);
    check(mode_byte, mem_m.mem[69]);
    check(addon_enable, 16'h0001);
    check(image_absent, 16'h0000);
    check(mem_m.starts, 16'h000e);
    check(cfg_ready, 16'h0001);
  endtask : test_valid

  initial begin
    test_absent();
    test_reject(8'hff, 8'hff, 8'h81, 4);
    test_reject(8'hff, 8'h12, 8'h83, 6);
    test_valid();
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire
